// ===== logic/qub_pkg.sv
// constants and carrier types for the host bus style select and channel decode
// assumes one 200 MHz system clock; all bus pins arrive asynchronously
// Behaviour
// - strap high strobe style, low direction style
// - direction style: write pin is direction, read ignored
// - direction style: reset pin active low
// - direction style: interrupts merged on open-source request
// - three low address bits pick the register
// - direction style: upper bits pick channel under select
// - strobe style: upper address pins select B, C
// - direction style: common select low enables channels
// - strobe style: common select is channel A only
// - strobe style: transfer only for selected channels
// - strobe style: four active-high interrupt outputs
package qub_pkg;

    localparam int unsigned QUB_CHANNELS   = 4;
    localparam int unsigned QUB_REG_BITS   = 3;
    localparam int unsigned QUB_CHAN_BITS  = 2;
    localparam int unsigned QUB_SYNC_WIDTH = 12;

    // channel index of each channel inside the select vector
    localparam logic [1:0] QUB_CHAN_A = 2'h0;
    localparam logic [1:0] QUB_CHAN_B = 2'h1;
    localparam logic [1:0] QUB_CHAN_C = 2'h2;
    localparam logic [1:0] QUB_CHAN_D = 2'h3;

    localparam logic [3:0] QUB_SEL_NONE = 4'h0;
    localparam logic [2:0] QUB_REG_RST  = 3'h0;

    typedef enum logic {QUB_DIRECTION, QUB_STROBE} qub_style_t;

    // raw bus pins as seen after the synchroniser
    typedef struct packed {
        logic       bus_style;
        logic       device_reset;
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic       channel_a_select_n;
        logic       channel_d_select_n;
        logic [1:0] channel_address_bits;
        logic [2:0] register_address_bits;
        logic       spare;
    } qub_pins_t;

    // synchroniser reset level: strap pulled up, strobes and selects released,
    // so no false access appears in the cycles after reset; style reads strobe in those cycles whatever the strap
    localparam qub_pins_t QUB_PINS_IDLE = '{
        bus_style:             1'b1,
        device_reset:          1'b0,
        read_strobe_n:         1'b1,
        write_strobe_n:        1'b1,
        channel_a_select_n:    1'b1,
        channel_d_select_n:    1'b1,
        channel_address_bits:  2'h3,
        register_address_bits: 3'h0,
        spare:                 1'b0
    };

    // decoded access toward the channels
    typedef struct packed {
        logic [3:0] chan_sel;
        logic       rd;
        logic       wr;
        logic [2:0] reg_addr;
    } qub_access_t;

endpackage

// ===== logic/qub_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes each bit is a quasi-static level; no bus coherency is promised
module qub_sync
    import qub_pkg::*;
#(
    parameter int unsigned     WIDTH       = QUB_SYNC_WIDTH,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ===== logic/qub_bus_select.sv
// host bus style select, channel decode and interrupt routing for four channels
// assumes the host holds address and selects stable around its strobes
module qub_bus_select
    import qub_pkg::*;
(
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       BUS_STYLE_IN,
    input  wire logic       DEVICE_RESET_IN,
    input  wire logic       READ_STROBE_N_IN,
    input  wire logic       WRITE_STROBE_N_IN,
    input  wire logic       CHANNEL_A_SELECT_N_IN,
    input  wire logic       CHANNEL_D_SELECT_N_IN,
    input  wire logic [1:0] CHANNEL_ADDRESS_BITS_IN,
    input  wire logic [2:0] REGISTER_ADDRESS_BITS_IN,
    input  wire logic [3:0] CHAN_INT_COND_IN,
    output logic      [3:0] CHAN_SEL_OUT,
    output logic            CHAN_READ_OUT,
    output logic            CHAN_WRITE_OUT,
    output logic      [2:0] CHAN_REG_ADDR_OUT,
    output logic            UART_RESET_OUT,
    output logic      [3:0] INT_OUT,
    output logic            IRQ_OUT,
    output logic            IRQ_OE_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    qub_pins_t raw;
    qub_pins_t s;
    logic [3:0] int_cond;

    always_comb begin
        raw.bus_style             = BUS_STYLE_IN;
        raw.device_reset          = DEVICE_RESET_IN;
        raw.read_strobe_n         = READ_STROBE_N_IN;
        raw.write_strobe_n        = WRITE_STROBE_N_IN;
        raw.channel_a_select_n    = CHANNEL_A_SELECT_N_IN;
        raw.channel_d_select_n    = CHANNEL_D_SELECT_N_IN;
        raw.channel_address_bits  = CHANNEL_ADDRESS_BITS_IN;
        raw.register_address_bits = REGISTER_ADDRESS_BITS_IN;
        raw.spare                 = 1'b0;
    end

    // reset to the idle pin levels: an all-zero reset would look like an
    // active common select with a write in direction style
    qub_sync #(.WIDTH(QUB_SYNC_WIDTH), .RESET_VALUE(QUB_PINS_IDLE)) u_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_n_in (RST_N_IN),
        .async_in (raw),
        .sync_out (s)
    );

    // interrupt conditions come from the channel logic on this clock: no sync
    assign int_cond = CHAN_INT_COND_IN;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    qub_style_t  style;
    qub_access_t next_acc;
    qub_access_t acc;
    logic        next_reset;
    logic [3:0]  next_int;
    logic        next_irq;
    logic        next_irq_oe;
    logic        any_int;

    assign style   = s.bus_style ? QUB_STROBE : QUB_DIRECTION;
    assign any_int = |int_cond;

    always_comb begin
        next_acc          = '0;
        next_acc.reg_addr = s.register_address_bits;
        case (style)
            QUB_STROBE: begin
                next_acc.chan_sel[QUB_CHAN_A] = ~s.channel_a_select_n;
                // upper pins select B and C
                next_acc.chan_sel[QUB_CHAN_B] = ~s.channel_address_bits[0];
                next_acc.chan_sel[QUB_CHAN_C] = ~s.channel_address_bits[1];
                next_acc.chan_sel[QUB_CHAN_D] = ~s.channel_d_select_n;
                // strobes only count with a select
                next_acc.rd = (next_acc.chan_sel != QUB_SEL_NONE) & ~s.read_strobe_n;
                next_acc.wr = (next_acc.chan_sel != QUB_SEL_NONE) & ~s.write_strobe_n;
            end
            QUB_DIRECTION: begin
                // common select enables, upper bits choose
                if (!s.channel_a_select_n) begin
                    next_acc.chan_sel[s.channel_address_bits] = 1'b1;
                    // write pin is direction, read pin ignored
                    next_acc.rd = s.write_strobe_n;
                    next_acc.wr = ~s.write_strobe_n;
                end
            end
            default: begin
                next_acc = '0;
            end
        endcase
    end

    always_comb begin
        next_reset = (style == QUB_STROBE) ? s.device_reset : ~s.device_reset;
        if (style == QUB_STROBE) begin
            next_int    = int_cond;
            next_irq    = 1'b0;
            next_irq_oe = 1'b0;
        end else begin
            next_int    = QUB_SEL_NONE;
            next_irq    = any_int;
            next_irq_oe = any_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output registers

    // uart reset held active while the system reset is applied
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            acc            <= '0;
            UART_RESET_OUT <= 1'b1;
            INT_OUT        <= QUB_SEL_NONE;
            IRQ_OUT        <= 1'b0;
            IRQ_OE_OUT     <= 1'b0;
        end else begin
            acc            <= next_acc;
            UART_RESET_OUT <= next_reset;
            INT_OUT        <= next_int;
            IRQ_OUT        <= next_irq;
            IRQ_OE_OUT     <= next_irq_oe;
        end
    end

    assign CHAN_SEL_OUT      = acc.chan_sel;
    assign CHAN_READ_OUT     = acc.rd;
    assign CHAN_WRITE_OUT    = acc.wr;
    assign CHAN_REG_ADDR_OUT = acc.reg_addr;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_dir_sel;
        !s.bus_style && !s.channel_a_select_n;
    endsequence

    // strobe style with every individual select released
    sequence s_strobe_none;
        s.bus_style && s.channel_a_select_n && s.channel_d_select_n
        && (&s.channel_address_bits);
    endsequence

    sequence s_strobe_rd;
        s.bus_style && !s.read_strobe_n
        && !(s.channel_a_select_n && s.channel_d_select_n && (&s.channel_address_bits));
    endsequence

    property p_style_strobe_int;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s.bus_style |=> (INT_OUT == $past(int_cond)) && !IRQ_OE_OUT;
    endproperty
    a_style_strobe_int: assert property (p_style_strobe_int)
        else $error("strobe style interrupts not routed per channel");

    property p_dir_rw;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_dir_sel |=> (CHAN_READ_OUT == $past(s.write_strobe_n))
                      && (CHAN_WRITE_OUT == !$past(s.write_strobe_n));
    endproperty
    a_dir_rw: assert property (p_dir_rw)
        else $error("direction input not steering read and write");

    property p_reset_pol;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        !s.bus_style ##0 s.device_reset |=> !UART_RESET_OUT;
    endproperty
    a_reset_pol: assert property (p_reset_pol)
        else $error("reset polarity wrong in direction style");

    property p_irq_merge;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (!s.bus_style && any_int) |=> IRQ_OUT && IRQ_OE_OUT && (INT_OUT == QUB_SEL_NONE);
    endproperty
    a_irq_merge: assert property (p_irq_merge)
        else $error("merged request not driven");

    property p_reg_addr;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        1'b1 |=> CHAN_REG_ADDR_OUT == $past(s.register_address_bits);
    endproperty
    a_reg_addr: assert property (p_reg_addr)
        else $error("register address not passed");

    property p_dir_chan;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_dir_sel |=> CHAN_SEL_OUT == (4'h1 << $past(s.channel_address_bits));
    endproperty
    a_dir_chan: assert property (p_dir_chan)
        else $error("channel decode wrong in direction style");

    property p_strobe_sel;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s.bus_style |=> CHAN_SEL_OUT[2:0] == ~$past({s.channel_address_bits,
                                                     s.channel_a_select_n});
    endproperty
    a_strobe_sel: assert property (p_strobe_sel)
        else $error("strobe style selects wrong");

    property p_no_sel_no_xfer;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_strobe_none |=> !CHAN_READ_OUT && !CHAN_WRITE_OUT && (CHAN_SEL_OUT == QUB_SEL_NONE);
    endproperty
    a_no_sel_no_xfer: assert property (p_no_sel_no_xfer)
        else $error("transfer without select");

    property p_strobe_rd;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        s_strobe_rd |=> CHAN_READ_OUT;
    endproperty
    a_strobe_rd: assert property (p_strobe_rd)
        else $error("selected read strobe not passed on");

    property p_dir_idle;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (!s.bus_style && s.channel_a_select_n) |=> !CHAN_READ_OUT && !CHAN_WRITE_OUT
                                                   && (CHAN_SEL_OUT == QUB_SEL_NONE);
    endproperty
    a_dir_idle: assert property (p_dir_idle)
        else $error("access without common select");

endmodule

// ===== verification/qub_host_model.sv
// host processor model driving the parallel bus pins of the block
// assumes the bench hands it whole pin sets; the data bus is outside the block
module qub_host_model
    import qub_pkg::*;
(
    input  wire logic clk_in,
    output qub_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // all strobes and selects idle until the first access
    initial begin
        pins_out = '1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // host places address and selects
    // a pin set moves as a whole just after an edge and holds until the next call,
    // so the synchroniser never samples a half-changed bus
    task automatic put(input qub_pins_t p);
        @(posedge clk_in);
        #1;
        pins_out = p;
    endtask
endmodule

// ===== verification/quad_uart_host_bus_select_tb.sv
// self-checking bench for the host bus style select block
// assumes the host model drives every bus pin; interrupt conditions come from here
module quad_uart_host_bus_select_tb
    import qub_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rst_n;
    logic [3:0]  cond;
    qub_pins_t   pins;
    qub_pins_t   p;
    logic [3:0]  sel;
    logic [3:0]  ints;
    logic        rd;
    logic        wr;
    logic        urst;
    logic        irq;
    logic        irq_oe;
    logic [2:0]  raddr;
    logic [15:0] got;
    int          num_errors;
    int          checks_done;

    qub_host_model host (.clk_in(clk), .pins_out(pins));

    qub_bus_select dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .BUS_STYLE_IN(pins.bus_style),
        .DEVICE_RESET_IN(pins.device_reset), .READ_STROBE_N_IN(pins.read_strobe_n),
        .WRITE_STROBE_N_IN(pins.write_strobe_n),
        .CHANNEL_A_SELECT_N_IN(pins.channel_a_select_n),
        .CHANNEL_D_SELECT_N_IN(pins.channel_d_select_n),
        .CHANNEL_ADDRESS_BITS_IN(pins.channel_address_bits),
        .REGISTER_ADDRESS_BITS_IN(pins.register_address_bits), .CHAN_INT_COND_IN(cond),
        .CHAN_SEL_OUT(sel), .CHAN_READ_OUT(rd), .CHAN_WRITE_OUT(wr),
        .CHAN_REG_ADDR_OUT(raddr), .UART_RESET_OUT(urst), .INT_OUT(ints),
        .IRQ_OUT(irq), .IRQ_OE_OUT(irq_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reference decode, written with plain integers
    function automatic logic [15:0] model_access(input qub_pins_t q);
        int s, r, w, a, rs;
        if (q.bus_style) begin
            s = {!q.channel_d_select_n, !q.channel_address_bits[1],
                 !q.channel_address_bits[0], !q.channel_a_select_n};
            r = (s != 0) && !q.read_strobe_n;
            w = (s != 0) && !q.write_strobe_n;
            rs = q.device_reset;
        end else begin
            s = q.channel_a_select_n ? 0 : (1 << q.channel_address_bits);
            r = !q.channel_a_select_n && q.write_strobe_n;
            w = !q.channel_a_select_n && !q.write_strobe_n;
            rs = !q.device_reset;
        end
        a = q.register_address_bits;
        return {6'h0, s[3:0], r[0], w[0], a[2:0], rs[0]};
    endfunction

    function automatic logic [15:0] model_int(input logic style, input logic [3:0] c);
        int any;
        any = (c != 0);
        return style ? {10'h0, c, 2'h0} : {14'h0, any[0], any[0]};
    endfunction

    task automatic apply(input qub_pins_t q, input logic [3:0] c);
        host.put(q);
        cond = c;
        repeat (4) @(posedge clk);
        #1;
        got = {6'h0, sel, rd, wr, raddr, urst};
        check("access", got, model_access(q));
        got = {10'h0, ints, irq_oe, irq & irq_oe};
        check("interrupts", got, model_int(q.bus_style, c));
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #20us;
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [3:0] n;
        rst_n = 1'b0;
        cond = 4'h0;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(32'h176332c9));
        repeat (8) @(posedge clk);
        #1;
        check("reset", {sel, rd, wr, raddr, urst, ints, irq, irq_oe}, 16'h0040);
        rst_n = 1'b1;
        $display("reset test done");
        // every channel and both operations in both styles; channel 4 means no select
        for (int st = 1; st >= 0; st--) begin
            for (int ch = 0; ch < 5; ch++) begin
                for (int op = 0; op < 2; op++) begin
                    p = '1;
                    p.bus_style = st[0];
                    p.device_reset = 1'($urandom);
                    p.register_address_bits = 3'($urandom);
                    n = ~(4'h1 << ch);
                    if (st != 0) begin
                        {p.channel_d_select_n, p.channel_address_bits} = n[3:1];
                        p.channel_a_select_n = n[0];
                        p.write_strobe_n = (op == 0);
                        p.read_strobe_n = (op == 1);
                    end else begin
                        p.channel_a_select_n = (ch == 4);
                        p.channel_address_bits = 2'(ch);
                        p.write_strobe_n = (op == 0);
                        p.read_strobe_n = 1'($urandom);
                        p.channel_d_select_n = 1'($urandom);
                    end
                    apply(p, 4'($urandom));
                end
            end
        end
        $display("directed decode test done");
        for (int i = 0; i < 60; i++) begin
            p = qub_pins_t'(12'($urandom));
            if (p.bus_style && !p.read_strobe_n) begin
                p.write_strobe_n = 1'b1;
            end
            apply(p, 4'($urandom));
        end
        $display("random decode test done");
        report_and_stop();
    end
endmodule
